// file: design/ntc_monitor.sv
// thermistor monitor with two-wire serial register target

module ntc_monitor import ntc_pkg::*; #(
	parameter int BIAS_CYCLES   = BIAS_CYC,
	parameter int PERIOD_CYCLES = PERIOD_CYC,
	parameter int SECOND_CYCLES = SECOND_CYC,
	parameter int INT_CYCLES    = INT_CYC
) (
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_srst,
	// serial bus pins
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda,
	output logic            o_sda_oe,
	// sensor and supply
	input  wire logic       i_input_supply,
	input  wire logic [9:0] i_ts_mv,
	output logic            o_ts_bias,
	// charger control
	output logic            o_charge_suspend,
	output logic            o_timer_halt,
	output logic [7:0]      o_charge_current,
	output logic [7:0]      o_vbat_reg,
	// interrupt, active low
	output logic            o_int_n
);

	// ---------------------------------------------------------------
	// synchronisers and bus edges
	// ---------------------------------------------------------------
	logic       scl_s, sda_s, supply_s;
	logic [9:0] ts_s;
	logic       scl_d_r, sda_d_r;
	logic       scl_rise, scl_fall, start, stop;

	sync2 #(.W(3)) u_sync_pins (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.i_d     ({i_scl, i_sda, i_input_supply}),
		.o_q     ({scl_s, sda_s, supply_s})
	);
	sync2 #(.W(10)) u_sync_ts (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.i_d     (i_ts_mv),
		.o_q     (ts_s)
	);

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	// clock from the controller, sampled: target only
	assign scl_rise = scl_s & ~scl_d_r;
	assign scl_fall = ~scl_s & scl_d_r;
	assign start    = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop     = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// ---------------------------------------------------------------
	// serial target
	// ---------------------------------------------------------------
	typedef enum {I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD,
		I_RACK} i2c_st_t;
	i2c_st_t    ist_r, ist_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, rd_val;
	logic       rw_r, rw_nxt, ptrph_r, ptrph_nxt, oe_r, oe_nxt;
	logic       wr_en, rd_load, load_go, rd_hit, thr_hit, rd_clr;

	// bit engine: shift on rise, drive on fall
	always_comb begin
		ist_nxt = ist_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		rw_nxt = rw_r;
		ptr_nxt = ptr_r;
		ptrph_nxt = ptrph_r;
		oe_nxt = oe_r;
		wr_en = 1'b0;
		rd_load = 1'b0;
		load_go = 1'b0;
		if (stop) begin
			ist_nxt = I_IDLE;
			oe_nxt = 1'b0;
		end else if (start) begin
			ist_nxt = I_ADDR;
			bit_nxt = 4'h0;
			oe_nxt = 1'b0;
		end else begin
			case (ist_r)
				I_ADDR, I_WR: begin
					if (scl_rise && bit_r != 4'h8) begin
						sh_nxt = {sh_r[6:0], sda_s};
						bit_nxt = bit_r + 4'h1;
					end
					if (scl_fall && bit_r == 4'h8) begin
						bit_nxt = 4'h0;
						if (ist_r == I_ADDR) begin
							if (sh_r[7:1] == DEV_ADDR) begin
								rw_nxt = sh_r[0];
								ptrph_nxt = ~sh_r[0];
								oe_nxt = 1'b1;
								ist_nxt = I_AACK;
							end else begin
								ist_nxt = I_IDLE;
							end
						end else begin
							oe_nxt = 1'b1;
							ist_nxt = I_WACK;
							if (ptrph_r) begin
								ptr_nxt = sh_r;
								ptrph_nxt = 1'b0;
							end else begin
								wr_en = 1'b1;
								ptr_nxt = ptr_r + 8'h01;
							end
						end
					end
				end
				I_AACK, I_WACK: begin
					if (scl_fall && rw_r) begin
						load_go = 1'b1;
					end else if (scl_fall) begin
						oe_nxt = 1'b0;
						ist_nxt = I_WR;
					end
				end
				I_RD: begin
					if (scl_fall && bit_r == 4'h8) begin
						oe_nxt = 1'b0;
						ist_nxt = I_RACK;
					end else if (scl_fall) begin
						sh_nxt = {sh_r[6:0], 1'b0};
						oe_nxt = ~sh_r[6];
						bit_nxt = bit_r + 4'h1;
					end
				end
				I_RACK: begin
					// controller acknowledges reads
					if (scl_rise && sda_s) begin
						ist_nxt = I_IDLE;
					end else if (scl_fall) begin
						load_go = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (load_go) begin
			sh_nxt = rd_val;
			oe_nxt = ~rd_val[7];
			rd_load = 1'b1;
			ptr_nxt = ptr_r + 8'h01;
			bit_nxt = 4'h1;
			ist_nxt = I_RD;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ist_r <= I_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			rw_r <= 1'b0;
			ptr_r <= 8'h00;
			ptrph_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			ist_r <= ist_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			rw_r <= rw_nxt;
			ptr_r <= ptr_nxt;
			ptrph_r <= ptrph_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign o_sda = 1'b0;
	assign o_sda_oe = oe_r;

	// ---------------------------------------------------------------
	// register file; fault flags clear on read, manual bit when a sample ends
	// ---------------------------------------------------------------
	logic [9:0] thr_r [NUM_THR];
	logic [9:0] thr_nxt [NUM_THR];
	logic [1:0] mode_r, mode_nxt;
	logic       auto_r, auto_nxt, manual_r, manual_nxt;
	logic       meas_en_r, meas_en_nxt;
	logic [2:0] frac_r, frac_nxt;
	logic [7:0] wvbat_r, wvbat_nxt, fast_charge_current_r, fast_charge_current_nxt, vbat_r, vbat_nxt;
	logic [4:0] fault_r, fault_nxt, zone_r, set_flags;
	logic [9:0] sample_r;
	logic       meas_done;

	// read mux, unmapped reads give all ones
	always_comb begin
		rd_val = 8'hFF;
		thr_hit = 1'b0;
		for (int i = 0; i < NUM_THR; i++) begin
			if (ptr_r == 8'(OFS_THR + 2 * i)) begin
				rd_val = thr_r[i][7:0];
				thr_hit = 1'b1;
			end
			if (ptr_r == 8'(OFS_THR + 2 * i + 1)) begin
				rd_val = {6'h00, thr_r[i][9:8]};
				thr_hit = 1'b1;
			end
		end
		rd_hit = 1'b1;
		case (ptr_r)
			OFS_MODE:      rd_val = {6'h00, mode_r};
			OFS_READ_CFG:  rd_val = {6'h00, manual_r, auto_r};
			OFS_FRAC:      rd_val = {5'h00, frac_r};
			OFS_WARM_VBAT: rd_val = wvbat_r;
			OFS_FAST_CHARGE_CURRENT:      rd_val = fast_charge_current_r;
			OFS_VBAT:      rd_val = vbat_r;
			OFS_FAULT:     rd_val = {3'h0, fault_r};
			OFS_STATUS:    rd_val = {3'h0, zone_r};
			OFS_SAMPLE_L:  rd_val = sample_r[7:0];
			OFS_SAMPLE_H:  rd_val = {6'h00, sample_r[9:8]};
			OFS_TRIG:      rd_val = {5'h00, meas_en_r, 2'h0};
			default:       rd_hit = thr_hit;
		endcase
	end

	assign rd_clr = rd_load && (ptr_r == OFS_FAULT);

	// host writes; hardware flag set beats read clear
	always_comb begin
		thr_nxt = thr_r;
		mode_nxt = mode_r;
		auto_nxt = auto_r;
		manual_nxt = meas_done ? 1'b0 : manual_r;
		meas_en_nxt = meas_en_r;
		frac_nxt = frac_r;
		wvbat_nxt = wvbat_r;
		fast_charge_current_nxt = fast_charge_current_r;
		vbat_nxt = vbat_r;
		fault_nxt = (rd_clr ? 5'h00 : fault_r) | set_flags;
		if (wr_en) begin
			for (int i = 0; i < NUM_THR; i++) begin
				if (ptr_r == 8'(OFS_THR + 2 * i)) begin
					thr_nxt[i][7:0] = sh_r;
				end
				if (ptr_r == 8'(OFS_THR + 2 * i + 1)) begin
					thr_nxt[i][9:8] = sh_r[1:0];
				end
			end
			case (ptr_r)
				OFS_MODE:      mode_nxt = sh_r[1:0];
				OFS_READ_CFG: begin
					auto_nxt = sh_r[AUTO_BIT];
					manual_nxt = manual_nxt | sh_r[MANUAL_BIT];
				end
				OFS_FRAC:      frac_nxt = sh_r[2:0];
				OFS_WARM_VBAT: wvbat_nxt = sh_r;
				OFS_FAST_CHARGE_CURRENT:      fast_charge_current_nxt = sh_r;
				OFS_VBAT:      vbat_nxt = sh_r;
				OFS_TRIG:      meas_en_nxt = sh_r[TRIG_BIT];
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			thr_r[FB_COLD] <= RST_COLD;
			thr_r[FB_COOL] <= RST_COOL;
			thr_r[FB_WARM] <= RST_WARM;
			thr_r[FB_HOT]  <= RST_HOT;
			thr_r[FB_OPEN] <= RST_OPEN;
			mode_r <= MODE_FULL;
			auto_r <= 1'b0;
			manual_r <= 1'b0;
			meas_en_r <= 1'b0;
			frac_r <= RST_FRAC;
			wvbat_r <= RST_WARM_VBAT;
			fast_charge_current_r <= RST_FAST_CHARGE_CURRENT;
			vbat_r <= RST_VBAT;
			fault_r <= 5'h00;
		end else begin
			thr_r <= thr_nxt;
			mode_r <= mode_nxt;
			auto_r <= auto_nxt;
			manual_r <= manual_nxt;
			meas_en_r <= meas_en_nxt;
			frac_r <= frac_nxt;
			wvbat_r <= wvbat_nxt;
			fast_charge_current_r <= fast_charge_current_nxt;
			vbat_r <= vbat_nxt;
			fault_r <= fault_nxt;
		end
	end

	// ---------------------------------------------------------------
	// sampling, classification and charger control
	// ---------------------------------------------------------------
	typedef enum {S_IDLE, S_BIAS} samp_st_t;
	samp_st_t         sst_r, sst_nxt;
	logic [CNT_W-1:0] bcnt_r, bcnt_nxt, pcnt_r, pcnt_nxt, plim;
	logic [INT_W-1:0] icnt_r, icnt_nxt;
	logic [9:0]       sample_nxt;
	logic [4:0]       zone_nxt, newz;
	logic [11:0]      prod;
	logic             tick, trig_wr, samp_go;
	logic             susp_nxt, susp_r, halt_nxt, halt_r, int_act_r;
	logic [7:0]       cur_nxt, cur_r, vreg_nxt, vreg_r;

	assign trig_wr = wr_en && ptr_r == OFS_TRIG && sh_r[TRIG_BIT];

	always_comb begin
		plim = supply_s ? CNT_W'(PERIOD_CYCLES - 1)
			: CNT_W'(SECOND_CYCLES - 1);
		tick = pcnt_r >= plim;
		pcnt_nxt = tick ? '0 : pcnt_r + 1'b1;
		// periodic with supply; on battery by trigger, manual bit, or auto timer when enabled
		samp_go = supply_s ? tick
			: (trig_wr || manual_r || (meas_en_r && auto_r && tick));
		sst_nxt = sst_r;
		bcnt_nxt = bcnt_r;
		sample_nxt = sample_r;
		zone_nxt = zone_r;
		meas_done = 1'b0;
		// region from the latest reading
		newz = 5'h00;
		if (ts_s > thr_r[FB_OPEN]) newz[FB_OPEN] = 1'b1;
		else if (ts_s > thr_r[FB_COLD]) newz[FB_COLD] = 1'b1;
		else if (ts_s > thr_r[FB_COOL]) newz[FB_COOL] = 1'b1;
		else if (ts_s < thr_r[FB_HOT] || (thr_r[FB_HOT] >=
			thr_r[FB_WARM] && ts_s < thr_r[FB_WARM]))
			newz[FB_HOT] = 1'b1;
		else if (ts_s < thr_r[FB_WARM]) newz[FB_WARM] = 1'b1;
		case (sst_r)
			S_IDLE: begin
				if (samp_go) begin
					sst_nxt = S_BIAS;
					bcnt_nxt = '0;
				end
			end
			S_BIAS: begin
				bcnt_nxt = bcnt_r + 1'b1;
				if (bcnt_r == CNT_W'(BIAS_CYCLES - 1)) begin
					sst_nxt = S_IDLE;
					sample_nxt = ts_s;
					zone_nxt = newz;
					meas_done = 1'b1;
				end
			end
			default: sst_nxt = S_IDLE;
		endcase
		set_flags = meas_done ? (newz & ~zone_r) : 5'h00;
		// pulse on any crossing or fault
		if (meas_done && newz != zone_r) icnt_nxt = INT_W'(INT_CYCLES);
		else if (icnt_r != '0) icnt_nxt = icnt_r - 1'b1;
		else icnt_nxt = icnt_r;
		// cool current rounded down to whole steps
		prod = 12'(fast_charge_current_r) * 12'(4'h8 - {1'b0, frac_r});
		susp_nxt = 1'b0;
		halt_nxt = 1'b0;
		cur_nxt = fast_charge_current_r;
		vreg_nxt = vbat_r;
		if (zone_r[FB_OPEN]) begin
			susp_nxt = 1'b1;
			halt_nxt = 1'b1;
		end else if (mode_r == MODE_FULL || mode_r == MODE_HOTCOLD) begin
			if (zone_r[FB_HOT] || zone_r[FB_COLD]) begin
				susp_nxt = 1'b1;
				halt_nxt = 1'b1;
			end else if (mode_r == MODE_FULL && zone_r[FB_COOL]) begin
				cur_nxt = prod[10:3];
			end else if (mode_r == MODE_FULL && zone_r[FB_WARM]) begin
				vreg_nxt = wvbat_r;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			sst_r <= S_IDLE;
			bcnt_r <= '0;
			pcnt_r <= '0;
			sample_r <= 10'h000;
			zone_r <= 5'h00;
			icnt_r <= '0;
			int_act_r <= 1'b0;
			susp_r <= 1'b0;
			halt_r <= 1'b0;
			cur_r <= RST_FAST_CHARGE_CURRENT;
			vreg_r <= RST_VBAT;
		end else begin
			sst_r <= sst_nxt;
			bcnt_r <= bcnt_nxt;
			pcnt_r <= pcnt_nxt;
			sample_r <= sample_nxt;
			zone_r <= zone_nxt;
			icnt_r <= icnt_nxt;
			int_act_r <= icnt_nxt != '0;
			susp_r <= susp_nxt;
			halt_r <= halt_nxt;
			cur_r <= cur_nxt;
			vreg_r <= vreg_nxt;
		end
	end

	assign o_ts_bias = (sst_r == S_BIAS);
	assign o_int_n = ~int_act_r;
	assign o_charge_suspend = susp_r;
	assign o_timer_halt = halt_r;
	assign o_charge_current = cur_r;
	assign o_vbat_reg = vreg_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);
	sequence addr_done_s;
		scl_fall && ist_r == I_ADDR && bit_r == 4'h8 && !start && !stop;
	endsequence
	sequence sample_end_s;
		sst_r == S_BIAS && bcnt_r == CNT_W'(BIAS_CYCLES - 1);
	endsequence

	bias_period_a: assert property (supply_s && tick && sst_r == S_IDLE
		|=> o_ts_bias) else $error("no bias at period start");
	bias_ends_a: assert property (sample_end_s |=> !o_ts_bias ##0
		meas_done == 1'b0) else $error("bias window wrong length");
	int_pulse_a: assert property (meas_done && newz != zone_r
		|=> !o_int_n [*8]) else $error("interrupt pulse missing");
	fault_keep_a: assert property (!rd_clr |=>
		(fault_r & $past(fault_r)) == $past(fault_r))
		else $error("fault bit lost without read");
	// codes 2 and 3 both leave charging alone except for an open sensor, which suspends in every mode
	hot_stop_a: assert property (zone_r[FB_HOT] && (mode_r == MODE_FULL
		|| mode_r == MODE_HOTCOLD) |=> o_charge_suspend && o_timer_halt)
		else $error("hot did not suspend charge");
	open_stop_a: assert property (zone_r[FB_OPEN] |=> o_charge_suspend)
		else $error("open sensor did not stop charge");
	warm_vbat_a: assert property (mode_r == MODE_FULL && zone_r ==
		5'h04 |=> o_vbat_reg == $past(wvbat_r))
		else $error("warm regulation voltage wrong");
	trig_start_a: assert property (trig_wr && !supply_s &&
		sst_r == S_IDLE |=> o_ts_bias) else $error("trigger ignored");
	addr_nack_a: assert property (addr_done_s ##0 sh_r[7:1] != DEV_ADDR
		|=> ist_r == I_IDLE && !o_sda_oe) else $error("foreign address acked");
	ack_hold_a: assert property (ist_r == I_AACK && scl_s && !stop
		|-> o_sda_oe) else $error("address ack released early");
	unmapped_ff_a: assert property (rd_load && !rd_hit
		|=> sh_r == 8'hFF) else $error("unmapped read not all ones");

endmodule

// file: shared/ntc_pkg.sv
// package: offsets, defaults and timing of the thermistor monitor
package ntc_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ    = 50_000_000;
	localparam int BIAS_MS   = 25;
	localparam int PERIOD_MS = 225;
	localparam int SECOND_MS = 1000;
	localparam int INT_US    = 128;
	localparam int BIAS_CYC   = (CLK_HZ / 1000) * BIAS_MS;
	localparam int PERIOD_CYC = (CLK_HZ / 1000) * PERIOD_MS;
	localparam int SECOND_CYC = (CLK_HZ / 1000) * SECOND_MS;
	localparam int INT_CYC    = (CLK_HZ / 1_000_000) * INT_US;
	localparam int CNT_W      = 26;
	localparam int INT_W      = 13;

	// ---------------------------------------------------------------
	// serial target address
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_WRITE_FORM = 8'hD6;
	localparam logic [6:0] DEV_ADDR        = ADDR_WRITE_FORM[7:1];

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_THR       = 8'h40;
	localparam logic [7:0] OFS_MODE      = 8'h4A;
	localparam logic [7:0] OFS_READ_CFG  = 8'h4B;
	localparam logic [7:0] OFS_FRAC      = 8'h4C;
	localparam logic [7:0] OFS_WARM_VBAT = 8'h4D;
	localparam logic [7:0] OFS_FAST_CHARGE_CURRENT      = 8'h4E;
	localparam logic [7:0] OFS_VBAT      = 8'h4F;
	localparam logic [7:0] OFS_FAULT     = 8'h50;
	localparam logic [7:0] OFS_STATUS    = 8'h51;
	localparam logic [7:0] OFS_SAMPLE_L  = 8'h52;
	localparam logic [7:0] OFS_SAMPLE_H  = 8'h53;
	localparam logic [7:0] OFS_TRIG      = 8'h58;

	// ---------------------------------------------------------------
	// field positions and codes
	// ---------------------------------------------------------------
	localparam int FB_COLD = 0;
	localparam int FB_COOL = 1;
	localparam int FB_WARM = 2;
	localparam int FB_HOT  = 3;
	localparam int FB_OPEN = 4;
	localparam int NUM_THR = 5;
	localparam int TRIG_BIT   = 2;
	localparam int AUTO_BIT   = 0;
	localparam int MANUAL_BIT = 1;
	localparam logic [1:0] MODE_FULL    = 2'h0;
	localparam logic [1:0] MODE_HOTCOLD = 2'h1;
	localparam logic [1:0] MODE_OFF     = 2'h2;

	// ---------------------------------------------------------------
	// values after reset (thresholds in millivolts)
	// ---------------------------------------------------------------
	localparam logic [9:0] RST_COLD = 10'h249;
	localparam logic [9:0] RST_COOL = 10'h202;
	localparam logic [9:0] RST_WARM = 10'h109;
	localparam logic [9:0] RST_HOT  = 10'h109;
	localparam logic [9:0] RST_OPEN = 10'h384;
	localparam logic [7:0] RST_FAST_CHARGE_CURRENT = 8'h0C;
	localparam logic [7:0] RST_VBAT = 8'h64;
	localparam logic [7:0] RST_WARM_VBAT = 8'h50;
	localparam logic [2:0] RST_FRAC = 3'h4;

endpackage

// file: design/sync2.sv
// two-flop synchroniser for signals from outside the clock domain
module sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_srst,
	// asynchronous in, synchronised out
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// first stage read only by the second
	always_comb begin
		meta_nxt = i_d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			meta_r <= '1;
			o_q    <= '1;
		end else begin
			meta_r <= meta_nxt;
			o_q    <= q_nxt;
		end
	end

endmodule

// file: sim/bus_ctrl_model.sv
// two-wire bus controller model facing the serial target
module bus_ctrl_model (
	// clock
	input  wire logic i_clock,
	// bus wires
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus idles released, clock stands high outside frames
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	// wait whole clock cycles, four make half a bus bit
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
	endtask

	// start or repeated start
	task automatic start();
		o_sda_low <= 1'b0;
		tick(2);
		o_scl <= 1'b1;
		tick(4);
		o_sda_low <= 1'b1;
		tick(4);
		o_scl <= 1'b0;
		tick(2);
	endtask

	// one bit: data set in low phase, sampled mid high phase
	task automatic bit_x(input logic b, output logic r);
		o_sda_low <= ~b;
		tick(2);
		o_scl <= 1'b1;
		tick(2);
		r = i_sda;
		tick(2);
		o_scl <= 1'b0;
		tick(2);
	endtask

	// byte plus ack slot; m_ack pulls low after a read byte
	task automatic xfer(input logic [7:0] d, input logic m_ack,
		output logic [7:0] q, output logic s_ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(~m_ack, r);
		s_ack = ~r;
	endtask

	// stop, also used to abandon a frame early
	task automatic stop();
		o_sda_low <= 1'b1;
		tick(2);
		o_scl <= 1'b1;
		tick(4);
		o_sda_low <= 1'b0;
		tick(4);
	endtask
endmodule

// file: sim/test_ntc_temperature_monitor_i2c.sv
// self-checking bench for the thermistor monitor
module test_ntc_temperature_monitor_i2c import ntc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       supply = 1'b1;
	logic [9:0] mv = 10'h1e0;
	logic       scl, sda_low, sda_oe, bias, susp, halt, int_n;
	logic [7:0] cur, vreg;
	wire        sda = ~(sda_oe | sda_low);
	int         num_errors = 0;
	int         n_checks = 0;
	int         cyc = 0;
	integer     seed = 32'h0000_79ed;
	int         npulse = 0, run = 0, plen = 0;
	int         nbias = 0, bhi = 0, blen = 0, brise = 0, bgap = 0;
	int         mode = 0, frac = 4, prev = NUM_THR;
	// model thresholds in mV: cold cool warm hot open
	int         thr[5] = '{585, 514, 265, 265, 900};
	int         lo[6] = '{586, 515, 201, 100, 901, 320};
	int         span[6] = '{300, 70, 64, 100, 100, 194};
	int         seq[8] = '{1, 5, 2, 5, 3, 0, 4, 5};

	ntc_monitor #(.BIAS_CYCLES(20), .PERIOD_CYCLES(100),
		.SECOND_CYCLES(300), .INT_CYCLES(8)) i_ntc_monitor (
		.i_clock(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda),
		.o_sda(), .o_sda_oe(sda_oe), .i_input_supply(supply),
		.i_ts_mv(mv), .o_ts_bias(bias), .o_charge_suspend(susp),
		.o_timer_halt(halt), .o_charge_current(cur),
		.o_vbat_reg(vreg), .o_int_n(int_n));

	bus_ctrl_model ctl (.i_clock(clk), .i_sda(sda), .o_scl(scl),
		.o_sda_low(sda_low));

	always #10 clk = ~clk;

	// cycle count, timeout, interrupt and bias pulse measurement
	always @(posedge clk) begin
		cyc++;
		if (int_n === 1'b0) run++;
		else if (run != 0) begin
			plen = run;
			npulse++;
			run = 0;
		end
		if (bias === 1'b1) begin
			if (bhi == 0) begin
				bgap = cyc - brise;
				brise = cyc;
			end
			bhi++;
		end else if (bhi != 0) begin
			blen = bhi;
			nbias++;
			bhi = 0;
		end
		// ceiling far above the whole sequence, last in the process
		if (cyc == 80000) begin
			num_errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string w, input int e, input logic [15:0] g);
		n_checks++;
		if (g !== 16'(e)) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", w, 16'(e), g);
		end
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		logic [7:0] q;
		logic a0, a1, a2;
		ctl.start();
		ctl.xfer(ADDR_WRITE_FORM, 1'b0, q, a0);
		ctl.xfer(ofs, 1'b0, q, a1);
		ctl.xfer(d, 1'b0, q, a2);
		ctl.stop();
		chk("write ack", 7, {13'h0, a0, a1, a2});
	endtask

	task automatic rd(input logic [7:0] ofs, output logic [7:0] q);
		logic a0, a1, a2, a3;
		ctl.start();
		ctl.xfer(ADDR_WRITE_FORM, 1'b0, q, a0);
		ctl.xfer(ofs, 1'b0, q, a1);
		ctl.start();
		ctl.xfer(ADDR_WRITE_FORM | 8'h01, 1'b0, q, a2);
		ctl.xfer(8'hff, 1'b0, q, a3);
		ctl.stop();
		chk("read ack", 7, {13'h0, a0, a1, a2});
	endtask

	// low byte first keeps the interim value harmless
	task automatic wthr(input int i, input int v);
		wr(OFS_THR + 8'(2 * i), 8'(v));
		wr(OFS_THR + 8'(2 * i + 1), 8'(v >> 8));
		thr[i] = v;
	endtask

	function automatic int region(input int v);
		if (v > thr[FB_OPEN]) return FB_OPEN;
		if (v > thr[FB_COLD]) return FB_COLD;
		if (v > thr[FB_COOL]) return FB_COOL;
		if (v < thr[FB_HOT]) return FB_HOT;
		if (v < thr[FB_WARM]) return FB_WARM;
		return NUM_THR;
	endfunction

	task automatic wait_fall();
		int n;
		n = 0;
		while (bias !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		while (bias !== 1'b0 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n >= 400) chk("bias wait", 0, 16'h0001);
	endtask

	// apply a voltage between samples, check the response
	task automatic sample(input int v);
		int rg, np, ef;
		logic es;
		logic [7:0] q;
		wait_fall();
		mv <= v[9:0];
		wait_fall();
		np = npulse;
		rg = region(v);
		repeat (12) @(posedge clk);
		es = rg == FB_OPEN || (mode != 2 && (rg == FB_COLD || rg == FB_HOT));
		chk("suspend", es, {15'h0, susp});
		chk("timer halt", es, {15'h0, halt});
		chk("current", (mode == 0 && rg == FB_COOL) ?
			12 * (8 - frac) / 8 : 12, {8'h0, cur});
		chk("vbat", (mode == 0 && rg == FB_WARM) ?
			RST_WARM_VBAT : RST_VBAT, {8'h0, vreg});
		chk("int count", rg != prev, 16'(npulse - np));
		if (rg != prev) chk("int width", 8, 16'(plen));
		ef = (rg != prev && rg != NUM_THR) ? 1 << rg : 0;
		rd(OFS_FAULT, q);
		chk("fault flags", ef, {8'h0, q});
		if (ef != 0) begin
			rd(OFS_FAULT, q);
			chk("flags cleared", 0, {8'h0, q});
		end
		prev = rg;
	endtask

	// main sequence
	initial begin
		logic [7:0] q;
		logic a;
		int nb, np;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			rd(OFS_THR + 8'(i), q);
			chk("thr reset", (thr[i / 2] >> (8 * (i % 2))) & 255,
				{8'h0, q});
		end
		rd(OFS_FAST_CHARGE_CURRENT, q);
		chk("fast_charge_current reset", RST_FAST_CHARGE_CURRENT, {8'h0, q});
		// two-byte read: controller acks the first byte, target goes on
		ctl.start();
		ctl.xfer(ADDR_WRITE_FORM, 1'b0, q, a);
		ctl.xfer(OFS_FAST_CHARGE_CURRENT, 1'b0, q, a);
		ctl.start();
		ctl.xfer(ADDR_WRITE_FORM | 8'h01, 1'b0, q, a);
		ctl.xfer(8'hff, 1'b1, q, a);
		chk("burst first byte", RST_FAST_CHARGE_CURRENT, {8'h0, q});
		ctl.xfer(8'hff, 1'b0, q, a);
		ctl.stop();
		chk("burst second byte", RST_VBAT, {8'h0, q});
		rd(8'h60, q);
		chk("unmapped read", 255, {8'h0, q});
		ctl.start();
		ctl.xfer(8'ha0, 1'b0, q, a);
		ctl.stop();
		chk("foreign ack", 0, {15'h0, a});
		ctl.start();
		ctl.xfer(ADDR_WRITE_FORM, 1'b0, q, a);
		ctl.xfer(OFS_VBAT, 1'b0, q, a);
		ctl.stop();
		rd(OFS_VBAT, q);
		chk("read after abort", RST_VBAT, {8'h0, q});
		repeat (300) @(posedge clk);
		chk("bias width", 20, 16'(blen));
		chk("bias period", 100, 16'(bgap));
		wthr(FB_HOT, 200);
		wr(OFS_FRAC, 8'h07);
		frac = 7;
		for (mode = 0; mode < 3; mode++) begin
			wr(OFS_MODE, 8'(mode));
			for (int k = 0; k < 8; k++) begin
				sample(lo[seq[k]] + {$random(seed)} % span[seq[k]]);
			end
		end
		mode = 0;
		wr(OFS_MODE, 8'h00);
		sample(480);
		wthr(FB_HOT, 300);
		sample(280);
		sample(480);
		supply <= 1'b0;
		repeat (200) @(posedge clk);
		nb = nbias;
		np = npulse;
		repeat (400) @(posedge clk);
		chk("idle bias", nb, 16'(nbias));
		mv <= 10'h3b6;
		wr(OFS_TRIG, 8'h04);
		repeat (40) @(posedge clk);
		chk("trigger bias", nb + 1, 16'(nbias));
		chk("trigger width", 20, 16'(blen));
		chk("battery fault int", np + 1, 16'(npulse));
		wr(OFS_READ_CFG, 8'h01);
		repeat (700) @(posedge clk);
		chk("auto interval", 300, 16'(bgap));
		wr(OFS_READ_CFG, 8'h00);
		repeat (400) @(posedge clk);
		nb = nbias;
		wr(OFS_READ_CFG, 8'h02);
		repeat (40) @(posedge clk);
		chk("manual bias", nb + 1, 16'(nbias));
		rd(OFS_READ_CFG, q);
		chk("manual bit clears", 0, {8'h0, q});
		test_done();
	end
endmodule
